// [logic/blit_data_pkg.sv]
// package: register map, field layout and carrier types of the blit data register bank
package blit_data_pkg;

   // ======================================================================
   // register byte addresses (low 24 bits of the processor address)
   localparam logic [23:0] OFS_SRC_DATA_LO   = 24'hF02240;
   localparam logic [23:0] OFS_SRC_DATA_HI   = 24'hF02244;
   localparam logic [23:0] OFS_DST_DATA_LO   = 24'hF02248;
   localparam logic [23:0] OFS_DST_DATA_HI   = 24'hF0224C;
   localparam logic [23:0] OFS_DST_DEPTH_LO  = 24'hF02250;
   localparam logic [23:0] OFS_DST_DEPTH_HI  = 24'hF02254;
   localparam logic [23:0] OFS_SRC_DEPTH1_LO = 24'hF02258;
   localparam logic [23:0] OFS_SRC_DEPTH1_HI = 24'hF0225C;
   localparam logic [23:0] OFS_SRC_DEPTH2_LO = 24'hF02260;
   localparam logic [23:0] OFS_SRC_DEPTH2_HI = 24'hF02264;
   localparam logic [23:0] OFS_PAT_DATA_LO   = 24'hF02268;
   localparam logic [23:0] OFS_PAT_DATA_HI   = 24'hF0226C;
   localparam logic [23:0] OFS_SHADE_STEP    = 24'hF02270;
   localparam logic [23:0] OFS_DEPTH_STEP    = 24'hF02274;
   localparam logic [23:0] OFS_SHADE_ALIAS3  = 24'hF0227C;
   localparam logic [23:0] OFS_SHADE_ALIAS2  = 24'hF02280;
   localparam logic [23:0] OFS_SHADE_ALIAS1  = 24'hF02284;
   localparam logic [23:0] OFS_STOP_CTRL     = 24'hF02288;
   localparam logic [23:0] OFS_ENGINE_STATUS = 24'hF02238;
   localparam logic [23:0] OFS_IRQ_STATUS    = 24'hF022A0;
   localparam logic [23:0] OFS_IRQ_CLEAR     = 24'hF022A4;
   localparam logic [23:0] OFS_IRQ_ENABLE    = 24'hF022A8;

   // ======================================================================
   // field positions
   localparam int STOP_RESUME_BIT  = 0;
   localparam int STOP_ABORT_BIT   = 1;
   localparam int STOP_ENABLE_BIT  = 2;
   localparam int STAT_IDLE_BIT    = 0;
   localparam int STAT_STOPPED_BIT = 1;
   localparam int IRQ_STOP_BIT     = 0;   // collision stop entered
   localparam int IRQ_ABORT_BIT    = 1;   // operation aborted while stopped
   localparam int IRQ_BITS         = 2;
   localparam int SHADE_FRAC_W     = 16;  // 8.16 shade value
   localparam int SHADE_INT_W      = 8;
   localparam int SHADE_INT_POS    = 8;   // integer byte sits above the colour byte
   localparam int XADD_PIXEL       = 1;

   // ======================================================================
   // reset values
   localparam logic [63:0] RST_DATA64 = 64'h0000_0000_0000_0000;
   localparam logic [31:0] RST_DATA32 = 32'h0000_0000;
   localparam logic [31:0] RD_ZERO    = 32'h0000_0000;

   // ======================================================================
   // carrier types
   typedef struct packed {
      logic       op_busy;        // an operation is running
      logic       write_inhibit;  // inner loop write inhibit this cycle
      logic [1:0] xadd_ctrl;      // destination X add control
      logic       background_write_back_enable; // write back destination on inhibit
      logic       bit_compare_enable;           // source bit compare active
      logic       data_compare_enable;          // data compare active
      logic [2:0] depth_compare_mode;           // nonzero selects a depth compare
   } engine_state_t;

   typedef struct packed {
      logic [63:0] src_data;
      logic [63:0] dst_data;
      logic [63:0] dst_depth;
      logic [63:0] src_depth1;
      logic [63:0] src_depth2;
      logic [63:0] pat_data;
      logic [31:0] shade_step;
      logic [31:0] depth_step;
   } data_bank_t;

endpackage

// [logic/blit_data_regs.sv]
// module: blit data register bank with collision stop control on a classic Wishbone slave
`timescale 1ns/100ps
module blit_data_regs
   import blit_data_pkg::*;
(
   input  wire logic          ref_clk,     // 100 MHz clock
   input  wire logic          rst_n,       // async reset, active low
   input  wire logic          cyc_i,       // wishbone cycle
   input  wire logic          stb_i,       // wishbone strobe
   input  wire logic          we_i,        // wishbone write
   input  wire logic [23:0]   adr_i,       // byte address
   input  wire logic [3:0]    sel_i,       // byte lanes
   input  wire logic [31:0]   dat_i,       // write data
   output logic      [31:0]   dat_o,       // read data
   output logic               ack_o,       // one-cycle acknowledge
   input  wire engine_state_t engine_i,    // engine state from the same clock
   output data_bank_t         bank_o,      // register contents to the data path
   output logic               halted_o,    // engine held by collision stop
   output logic               abort_o,     // one-cycle abort pulse to the engine
   output logic               stop_en_o,   // collision_stop_enable
   output logic               irq_o        // level interrupt
);

   // ======================================================================
   // state declarations
   typedef enum logic [1:0] {
      ST_RUN  = 2'b01,
      ST_HALT = 2'b10
   } stop_state_t;

   stop_state_t         stop_r;
   data_bank_t          bank_r;
   logic                stop_en_r;
   logic                abort_r;
   logic                ack_r;
   logic [31:0]         dat_r;
   logic [IRQ_BITS-1:0] irq_stat_r;
   logic [IRQ_BITS-1:0] irq_en_r;
   logic                irq_r;
   logic                wr_stb;
   logic                rd_stb;
   logic                stop_hit;
   logic                resume_req;
   logic                abort_req;
   logic [IRQ_BITS-1:0] irq_evt;

   // byte-lane merge of one 32-bit word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            res[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return res;
   endfunction

   // address match for a read or a write
   function automatic logic hit(input logic [23:0] a, input logic [23:0] ofs);
      return a == ofs;
   endfunction

   // ======================================================================
   // bus strobes: taken only on the first cycle, ack drops the cycle after
   assign wr_stb = cyc_i && stb_i && !ack_r && we_i;
   assign rd_stb = cyc_i && stb_i && !ack_r && !we_i;

   // answer every access in one cycle, unmapped included
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= cyc_i && stb_i && !ack_r;
      end
   end

   // ======================================================================
   // collision stop qualification
   // a stop needs pixel mode, no background write-back and an active compare
   assign stop_hit = stop_en_r && engine_i.op_busy && engine_i.write_inhibit
                     && (engine_i.xadd_ctrl == 2'(XADD_PIXEL)) && !engine_i.background_write_back_enable
                     && (engine_i.bit_compare_enable || engine_i.data_compare_enable
                         || (engine_i.depth_compare_mode != 3'h0));

   // resume and abort bits only count while halted, so stray writes cannot disturb a run
   assign resume_req = wr_stb && hit(adr_i, OFS_STOP_CTRL) && sel_i[0]
                       && dat_i[STOP_RESUME_BIT] && (stop_r == ST_HALT);
   assign abort_req  = wr_stb && hit(adr_i, OFS_STOP_CTRL) && sel_i[0]
                       && dat_i[STOP_ABORT_BIT] && (stop_r == ST_HALT);

   // stop state machine; abort beats resume when both are written
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         stop_r <= ST_RUN;
      end else begin
         unique case (stop_r)
            ST_RUN: begin
               if (stop_hit) begin
                  stop_r <= ST_HALT;
               end
            end
            ST_HALT: begin
               if (abort_req || resume_req) begin
                  stop_r <= ST_RUN;
               end
            end
         endcase
      end
   end

   // abort pulse tells the engine to return to idle
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         abort_r <= 1'b0;
      end else begin
         abort_r <= abort_req;
      end
   end

   // collision stop enable
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         stop_en_r <= 1'b0;
      end else if (wr_stb && hit(adr_i, OFS_STOP_CTRL) && sel_i[0]) begin
         stop_en_r <= dat_i[STOP_ENABLE_BIT];
      end
   end

   // ======================================================================
   // 64-bit data words: low half at the base offset, high half four bytes up
   // plain storage, the data path gives the meaning
   // the step words live here too, so the packed bank has a single writer
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         bank_r.shade_step <= RST_DATA32;
         bank_r.depth_step <= RST_DATA32;
         bank_r.src_data   <= RST_DATA64;
         bank_r.dst_data   <= RST_DATA64;
         bank_r.dst_depth  <= RST_DATA64;
         bank_r.src_depth1 <= RST_DATA64;
         bank_r.src_depth2 <= RST_DATA64;
         bank_r.pat_data   <= RST_DATA64;
      end else if (wr_stb) begin
         unique case (adr_i)
            OFS_SRC_DATA_LO:   bank_r.src_data[31:0]    <= merge(bank_r.src_data[31:0], dat_i, sel_i);
            OFS_SRC_DATA_HI:   bank_r.src_data[63:32]   <= merge(bank_r.src_data[63:32], dat_i, sel_i);
            OFS_DST_DATA_LO:   bank_r.dst_data[31:0]    <= merge(bank_r.dst_data[31:0], dat_i, sel_i);
            OFS_DST_DATA_HI:   bank_r.dst_data[63:32]   <= merge(bank_r.dst_data[63:32], dat_i, sel_i);
            OFS_DST_DEPTH_LO:  bank_r.dst_depth[31:0]   <= merge(bank_r.dst_depth[31:0], dat_i, sel_i);
            OFS_DST_DEPTH_HI:  bank_r.dst_depth[63:32]  <= merge(bank_r.dst_depth[63:32], dat_i, sel_i);
            OFS_SRC_DEPTH1_LO: bank_r.src_depth1[31:0]  <= merge(bank_r.src_depth1[31:0], dat_i, sel_i);
            OFS_SRC_DEPTH1_HI: bank_r.src_depth1[63:32] <= merge(bank_r.src_depth1[63:32], dat_i, sel_i);
            OFS_SRC_DEPTH2_LO: bank_r.src_depth2[31:0]  <= merge(bank_r.src_depth2[31:0], dat_i, sel_i);
            OFS_SRC_DEPTH2_HI: bank_r.src_depth2[63:32] <= merge(bank_r.src_depth2[63:32], dat_i, sel_i);
            OFS_PAT_DATA_LO:   bank_r.pat_data[31:0]    <= merge(bank_r.pat_data[31:0], dat_i, sel_i);
            OFS_PAT_DATA_HI:   bank_r.pat_data[63:32]   <= merge(bank_r.pat_data[63:32], dat_i, sel_i);
            // top byte of the shade step is kept as written, software zeroes it
            OFS_SHADE_STEP:    bank_r.shade_step        <= merge(bank_r.shade_step, dat_i, sel_i);
            OFS_DEPTH_STEP:    bank_r.depth_step        <= merge(bank_r.depth_step, dat_i, sel_i);
            // alias writes touch only shade integer and fraction fields
            OFS_SHADE_ALIAS3: begin
               bank_r.pat_data[48+SHADE_INT_POS +: SHADE_INT_W] <= dat_i[SHADE_FRAC_W +: SHADE_INT_W];
               bank_r.src_data[48 +: SHADE_FRAC_W]              <= dat_i[SHADE_FRAC_W-1:0];
            end
            OFS_SHADE_ALIAS2: begin
               bank_r.pat_data[32+SHADE_INT_POS +: SHADE_INT_W] <= dat_i[SHADE_FRAC_W +: SHADE_INT_W];
               bank_r.src_data[32 +: SHADE_FRAC_W]              <= dat_i[SHADE_FRAC_W-1:0];
            end
            OFS_SHADE_ALIAS1: begin
               bank_r.pat_data[16+SHADE_INT_POS +: SHADE_INT_W] <= dat_i[SHADE_FRAC_W +: SHADE_INT_W];
               bank_r.src_data[16 +: SHADE_FRAC_W]              <= dat_i[SHADE_FRAC_W-1:0];
            end
            default: ;
         endcase
      end
   end

   // ======================================================================
   // interrupts: set wins over a clear in the same cycle
   assign irq_evt = {abort_req, (stop_r == ST_RUN) && stop_hit};

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat_r <= '0;
      end else begin
         for (int i = 0; i < IRQ_BITS; i++) begin
            if (irq_evt[i]) begin
               irq_stat_r[i] <= 1'b1;
            end else if (wr_stb && hit(adr_i, OFS_IRQ_CLEAR) && sel_i[0] && dat_i[i]) begin
               irq_stat_r[i] <= 1'b0;
            end
         end
      end
   end

   // interrupt enable
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_en_r <= '0;
      end else if (wr_stb && hit(adr_i, OFS_IRQ_ENABLE) && sel_i[0]) begin
         irq_en_r <= dat_i[IRQ_BITS-1:0];
      end
   end

   // interrupt output registered so the port comes from a flip-flop
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(irq_stat_r & irq_en_r);
      end
   end

   // ======================================================================
   // read data; data registers are write-only and read as zero
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         dat_r <= RD_ZERO;
      end else if (rd_stb) begin
         dat_r <= RD_ZERO;
         if (hit(adr_i, OFS_ENGINE_STATUS)) begin
            dat_r[STAT_IDLE_BIT]    <= !engine_i.op_busy;
            dat_r[STAT_STOPPED_BIT] <= (stop_r == ST_HALT);
         end
         if (hit(adr_i, OFS_IRQ_STATUS)) begin
            dat_r[IRQ_BITS-1:0] <= irq_stat_r;
         end
      end else begin
         dat_r <= RD_ZERO;
      end
   end

   assign dat_o     = dat_r;
   assign ack_o     = ack_r;
   assign bank_o    = bank_r;
   assign halted_o  = stop_r[1];  // one-hot: the halt bit is the flip-flop itself
   assign abort_o   = abort_r;
   assign stop_en_o = stop_en_r;
   assign irq_o     = irq_r;

   // ======================================================================
   // assertions
   sequence s_resume_write;
      wr_stb && adr_i == OFS_STOP_CTRL && sel_i[0] && dat_i[STOP_RESUME_BIT] && !dat_i[STOP_ABORT_BIT];
   endsequence

   property p_stop_entry;
      @(posedge ref_clk) disable iff (!rst_n) (stop_r == ST_RUN) && stop_hit |=> halted_o;
   endproperty
   a_stop_entry: assert property (p_stop_entry) else $error("qualified inhibit did not halt");

   property p_no_stop_bkg;
      @(posedge ref_clk) disable iff (!rst_n)
         (stop_r == ST_RUN) && engine_i.background_write_back_enable |=> !halted_o;
   endproperty
   a_no_stop_bkg: assert property (p_no_stop_bkg) else $error("halted with background write-back");

   property p_resume;
      @(posedge ref_clk) disable iff (!rst_n) halted_o ##0 s_resume_write |=> !halted_o && !abort_o;
   endproperty
   a_resume: assert property (p_resume) else $error("resume did not release engine");

   property p_abort;
      @(posedge ref_clk) disable iff (!rst_n) abort_req |=> abort_o && !halted_o ##1 !abort_o;
   endproperty
   a_abort: assert property (p_abort) else $error("abort pulse wrong");

   property p_stop_en;
      @(posedge ref_clk) disable iff (!rst_n)
         wr_stb && adr_i == OFS_STOP_CTRL && sel_i[0] |=> stop_en_o == $past(dat_i[STOP_ENABLE_BIT]);
   endproperty
   a_stop_en: assert property (p_stop_en) else $error("stop enable not written");

   property p_status;
      @(posedge ref_clk) disable iff (!rst_n)
         rd_stb && adr_i == OFS_ENGINE_STATUS |=> ack_o && dat_o[STAT_STOPPED_BIT] == $past(halted_o);
   endproperty
   a_status: assert property (p_status) else $error("stopped status mismatch");

   property p_alias_colour;
      @(posedge ref_clk) disable iff (!rst_n)
         wr_stb && adr_i == OFS_SHADE_ALIAS1 |=> $stable(bank_o.pat_data[23:16])
         && bank_o.pat_data[31:24] == $past(dat_i[23:16]) && bank_o.src_data[31:16] == $past(dat_i[15:0]);
   endproperty
   a_alias_colour: assert property (p_alias_colour) else $error("alias write wrong");

   property p_idle_ctrl;
      @(posedge ref_clk) disable iff (!rst_n) !halted_o && !stop_hit |=> !halted_o && !abort_o;
   endproperty
   a_idle_ctrl: assert property (p_idle_ctrl) else $error("control acted while running");

   property p_shade_step;
      @(posedge ref_clk) disable iff (!rst_n)
         wr_stb && adr_i == OFS_SHADE_STEP && sel_i == 4'hF |=> bank_o.shade_step == $past(dat_i);
   endproperty
   a_shade_step: assert property (p_shade_step) else $error("shade step not stored");

   property p_dst_depth;
      @(posedge ref_clk) disable iff (!rst_n)
         wr_stb && adr_i == OFS_DST_DEPTH_HI && sel_i == 4'hF |=> bank_o.dst_depth[63:32] == $past(dat_i);
   endproperty
   a_dst_depth: assert property (p_dst_depth) else $error("depth word not stored");

   property p_src_data;
      @(posedge ref_clk) disable iff (!rst_n)
         wr_stb && adr_i == OFS_SRC_DATA_LO && sel_i == 4'hF |=> bank_o.src_data[31:0] == $past(dat_i);
   endproperty
   a_src_data: assert property (p_src_data) else $error("source word not stored");

   property p_dst_data;
      @(posedge ref_clk) disable iff (!rst_n)
         wr_stb && adr_i == OFS_DST_DATA_LO && sel_i == 4'hF |=> bank_o.dst_data[31:0] == $past(dat_i);
   endproperty
   a_dst_data: assert property (p_dst_data) else $error("destination word not stored");

   property p_src_depth1;
      @(posedge ref_clk) disable iff (!rst_n)
         wr_stb && adr_i == OFS_SRC_DEPTH1_LO && sel_i == 4'hF |=> bank_o.src_depth1[31:0] == $past(dat_i);
   endproperty
   a_src_depth1: assert property (p_src_depth1) else $error("first depth word not stored");

   property p_src_depth2;
      @(posedge ref_clk) disable iff (!rst_n)
         wr_stb && adr_i == OFS_SRC_DEPTH2_HI && sel_i == 4'hF |=> bank_o.src_depth2[63:32] == $past(dat_i);
   endproperty
   a_src_depth2: assert property (p_src_depth2) else $error("second depth word not stored");

   property p_pat_data;
      @(posedge ref_clk) disable iff (!rst_n)
         wr_stb && adr_i == OFS_PAT_DATA_HI && sel_i == 4'hF |=> bank_o.pat_data[63:32] == $past(dat_i);
   endproperty
   a_pat_data: assert property (p_pat_data) else $error("pattern word not stored");

   property p_depth_step;
      @(posedge ref_clk) disable iff (!rst_n)
         wr_stb && adr_i == OFS_DEPTH_STEP && sel_i == 4'hF |=> bank_o.depth_step == $past(dat_i);
   endproperty
   a_depth_step: assert property (p_depth_step) else $error("depth step not stored");

   // a disabled stop enable must keep a running engine running
   property p_stop_off;
      @(posedge ref_clk) disable iff (!rst_n) !stop_en_o && !halted_o |=> !halted_o;
   endproperty
   a_stop_off: assert property (p_stop_off) else $error("halted with stops disabled");

   // only a resume or an abort may release the engine
   property p_halt_hold;
      @(posedge ref_clk) disable iff (!rst_n) halted_o && !resume_req && !abort_req |=> halted_o;
   endproperty
   a_halt_hold: assert property (p_halt_hold) else $error("engine released without request");

   property p_stop_flag;
      @(posedge ref_clk) disable iff (!rst_n) (stop_r == ST_RUN) && stop_hit |=> irq_stat_r[IRQ_STOP_BIT];
   endproperty
   a_stop_flag: assert property (p_stop_flag) else $error("stop event flag not set");

   property p_abort_flag;
      @(posedge ref_clk) disable iff (!rst_n) abort_req |=> irq_stat_r[IRQ_ABORT_BIT];
   endproperty
   a_abort_flag: assert property (p_abort_flag) else $error("abort event flag not set");

   // interrupt level follows enabled status one cycle later
   property p_irq_on;
      @(posedge ref_clk) disable iff (!rst_n) |(irq_stat_r & irq_en_r) |=> irq_o;
   endproperty
   a_irq_on: assert property (p_irq_on) else $error("interrupt not raised");

   // classic bus: every request answered next cycle, for one cycle only
   property p_ack_answer;
      @(posedge ref_clk) disable iff (!rst_n) cyc_i && stb_i && !ack_o |=> ack_o;
   endproperty
   a_ack_answer: assert property (p_ack_answer) else $error("request not answered");

   property p_ack_pulse;
      @(posedge ref_clk) disable iff (!rst_n) ack_o |=> !ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("acknowledge stood two cycles");

endmodule

// [verif/test_blit_data_regs.sv]
// testbench: data word writes, shade aliases, collision stop control and interrupt
`timescale 1ns/100ps
module test_blit_data_regs
   import blit_data_pkg::*;
;
   logic          ref_clk;
   logic          rst_n;
   logic          cyc_r;
   logic          stb_r;
   logic          we_r;
   logic [23:0]   adr_r;
   logic [3:0]    sel_r;
   logic [31:0]   dat_r;
   logic [31:0]   dat_o;
   logic          ack_o;
   engine_state_t eng_r;
   data_bank_t    bank_o;
   logic          halted_o;
   logic          abort_o;
   logic          stop_en_o;
   logic          irq_o;
   int            miscompares;
   int            tests_run;
   int            aborts;
   logic [63:0]   src_e;
   logic [63:0]   pat_e;
   logic [31:0]   rd;
   logic [23:0]   ad;
   engine_state_t q;
   engine_state_t e;

   blit_data_regs i_dut (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .cyc_i     (cyc_r),
      .stb_i     (stb_r),
      .we_i      (we_r),
      .adr_i     (adr_r),
      .sel_i     (sel_r),
      .dat_i     (dat_r),
      .dat_o     (dat_o),
      .ack_o     (ack_o),
      .engine_i  (eng_r),
      .bank_o    (bank_o),
      .halted_o  (halted_o),
      .abort_o   (abort_o),
      .stop_en_o (stop_en_o),
      .irq_o     (irq_o)
   );

   // ======================================================================
   // clock and abort pulse counter
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // counting pulses catches a stuck-high abort as well as a missing one
   always @(posedge ref_clk) begin
      if (abort_o === 1'b1) aborts++;
   end

   // ======================================================================
   // shared tasks
   task give_verdict;
      $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task check(input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
         miscompares++;
      end
   endtask

   // one classic cycle; request held until ack is sampled high
   task wb_xfer(input logic w, input logic [23:0] a, input logic [31:0] d, input logic [3:0] s,
                output logic [31:0] r);
      int n;
      n = 0;
      @(posedge ref_clk);
      cyc_r <= 1'b1;
      stb_r <= 1'b1;
      we_r  <= w;
      adr_r <= a;
      dat_r <= d;
      sel_r <= s;
      do begin
         @(posedge ref_clk);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      r = dat_o;
      cyc_r <= 1'b0;
      stb_r <= 1'b0;
      we_r  <= 1'b0;
      if (n >= 20) begin
         miscompares++;
         give_verdict();
      end
   endtask

   task wb_write(input logic [23:0] a, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] dummy;
      wb_xfer(1'b1, a, d, s, dummy);
   endtask

   task wb_read(input logic [23:0] a, output logic [31:0] r);
      wb_xfer(1'b0, a, 32'h0000_0000, 4'hF, r);
   endtask

   task pause;
      repeat (4) @(posedge ref_clk);
   endtask

   // present an engine state, then drop the inhibit so a resume does not re-stop
   task try_stop(input engine_state_t s, input logic h);
      @(posedge ref_clk);
      eng_r <= s;
      repeat (3) @(posedge ref_clk);
      eng_r.write_inhibit <= 1'b0;
      check(halted_o, h);
   endtask

   // ======================================================================
   // main sequence
   initial begin
      rst_n = 1'b0; cyc_r = 1'b0; stb_r = 1'b0; we_r = 1'b0;
      adr_r = 24'h00_0000; sel_r = 4'h0; dat_r = 32'h0000_0000;
      eng_r = '0; miscompares = 0; tests_run = 0;
      q = '{1'b1, 1'b1, 2'h1, 1'b0, 1'b1, 1'b0, 3'h0};
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(negedge ref_clk);
      check({halted_o, stop_en_o, irq_o, ack_o}, 64'h0);
      // each 64-bit word: low half at base, high half at base plus four
      for (int i = 0; i < 6; i++) begin
         ad = OFS_SRC_DATA_LO + 24'(8 * i);
         wb_write(ad, 32'hC0DE_0000 | i, 4'hF);
         wb_write(ad + 24'h00_0004, 32'h5EED_0000 | i, 4'hF);
         @(negedge ref_clk);
         check(bank_o[447 - 64 * i -: 64], {32'h5EED_0000 | i, 32'hC0DE_0000 | i});
      end
      wb_write(OFS_SRC_DATA_LO, 32'hFFFF_FFFF, 4'h2);
      @(negedge ref_clk);
      check(bank_o.src_data, 64'h5EED_0000_C0DE_FF00);
      wb_write(OFS_SHADE_STEP, 32'h00AB_CDEF, 4'hF);
      wb_write(OFS_DEPTH_STEP, 32'h1234_5678, 4'hF);
      @(negedge ref_clk);
      check(bank_o.shade_step, 64'h00AB_CDEF);
      check(bank_o.depth_step, 64'h1234_5678);
      // write-only words and an unmapped place read as zero
      wb_read(OFS_PAT_DATA_LO, rd);
      check(rd, 64'h0);
      wb_read(24'hF0_22FC, rd);
      check(rd, 64'h0);
      // shade aliases touch only their own integer byte and fraction
      src_e = 64'h5EED_0000_C0DE_FF00;
      pat_e = 64'h5EED_0005_C0DE_0005;
      for (int i = 1; i < 4; i++) begin
         ad = (i == 1) ? OFS_SHADE_ALIAS1 : (i == 2) ? OFS_SHADE_ALIAS2 : OFS_SHADE_ALIAS3;
         wb_write(ad, {8'hEE, 8'h40 + 8'(i), 16'h1000 + 16'(i)}, 4'hF);
         pat_e[16 * i + 8 +: 8] = 8'h40 + 8'(i);
         src_e[16 * i +: 16]    = 16'h1000 + 16'(i);
         @(negedge ref_clk);
         check(bank_o.pat_data, pat_e);
         check(bank_o.src_data, src_e);
      end
      // ====================================================================
      // collision stop qualification
      wb_write(OFS_IRQ_ENABLE, 32'h0000_0003, 4'hF);
      try_stop(q, 1'b0);
      wb_write(OFS_STOP_CTRL, 32'h0000_0004, 4'hF);
      @(negedge ref_clk);
      check(stop_en_o, 64'h1);
      e = q; e.xadd_ctrl = 2'h2; try_stop(e, 1'b0);
      e = q;
      e.background_write_back_enable = 1'b1;
      try_stop(e, 1'b0);
      e = q;
      e.bit_compare_enable = 1'b0;
      try_stop(e, 1'b0);
      e.data_compare_enable = 1'b1;
      try_stop(e, 1'b1);
      pause();
      check(irq_o, 64'h1);
      wb_read(OFS_ENGINE_STATUS, rd);
      check(rd & 32'h0000_0003, 64'h2);
      wb_read(OFS_IRQ_STATUS, rd);
      check(rd & 32'h0000_0003, 64'h1);
      wb_write(OFS_IRQ_ENABLE, 32'h0000_0000, 4'hF);
      pause();
      check(irq_o, 64'h0);
      wb_write(OFS_IRQ_CLEAR, 32'h0000_0001, 4'hF);
      wb_read(OFS_IRQ_STATUS, rd);
      check(rd & 32'h0000_0003, 64'h0);
      wb_write(OFS_IRQ_ENABLE, 32'h0000_0003, 4'hF);
      // a zero resume bit, or lane zero not selected, leaves the engine held
      wb_write(OFS_STOP_CTRL, 32'h0000_0004, 4'hF);
      pause();
      check(halted_o, 64'h1);
      wb_write(OFS_STOP_CTRL, 32'h0000_0005, 4'hE);
      pause();
      check(halted_o, 64'h1);
      wb_write(OFS_STOP_CTRL, 32'h0000_0005, 4'hF);
      pause();
      check({halted_o, 32'(aborts)}, 64'h0);
      wb_read(OFS_ENGINE_STATUS, rd);
      check(rd & 32'h0000_0003, 64'h0);
      // depth compare stop, then abort
      e = q;
      e.bit_compare_enable = 1'b0;
      e.depth_compare_mode = 3'h4;
      try_stop(e, 1'b1);
      wb_write(OFS_STOP_CTRL, 32'h0000_0006, 4'hF);
      pause();
      check({halted_o, 32'(aborts)}, 64'h1);
      check(irq_o, 64'h1);
      wb_read(OFS_IRQ_STATUS, rd);
      check(rd & 32'h0000_0003, 64'h3);
      wb_write(OFS_IRQ_CLEAR, 32'h0000_0003, 4'hF);
      pause();
      check(irq_o, 64'h0);
      // bit compare stop, abort and resume together: abort wins
      try_stop(q, 1'b1);
      wb_write(OFS_STOP_CTRL, 32'h0000_0007, 4'hF);
      pause();
      check({halted_o, 32'(aborts)}, 64'h2);
      // not held: both bits are ignored
      wb_write(OFS_STOP_CTRL, 32'h0000_0007, 4'hF);
      pause();
      check({halted_o, 32'(aborts)}, 64'h2);
      wb_write(OFS_STOP_CTRL, 32'h0000_0000, 4'hF);
      @(negedge ref_clk);
      check(stop_en_o, 64'h0);
      give_verdict();
   end
endmodule
